// *** ext_bus_regs.svh ***
// Constants for the external bus host interface
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH
// ------------------------------------------------------------
// Widths
// ------------------------------------------------------------
`define ADDR_W 32
`define DATA_W 48
`define BANK_W 4
`define PAGE_SEL_W 3
// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define DRAM_BANK 0
`define PAGE_BASE_SHIFT 8
`define HOST_WAIT_CYCLES 4'h2
`define SLAVE_WAIT_CYCLES 4'h1
`define PAGE_SEL_RESET 3'h0
`define ACK_SETTLE_CYCLES 4'h4
`endif

// *** ext_bus_pkg.sv ***
// Types for the external bus host interface
`include "ext_bus_regs.svh"
package ext_bus_pkg;
   typedef logic [`ADDR_W-1:0] addr_t;
   typedef logic [`DATA_W-1:0] data_t;
   // One core-side access request
   typedef struct packed {
      logic valid;
      logic write;
      logic cond_ok;
      logic [`BANK_W-1:0] bank;
      addr_t addr;
      data_t data;
   } core_req_s;
   // Outputs and enables of the shared bus
   typedef struct packed {
      addr_t addr;
      data_t data;
      logic [`BANK_W-1:0] bank_sel_n;
      logic rd_n;
      logic wr_n;
      logic sw_n;
      logic page;
      logic addr_oe;
      logic data_oe;
      logic ctl_oe;
   } bus_drive_s;
   typedef enum logic [2:0] {
      M_IDLE,
      M_ADDR,
      M_WAIT,
      M_HOLD
   } master_state_e;
endpackage : ext_bus_pkg

// *** pin_sync.sv ***
// Two flip-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic enable_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta;
   // First stage is read only by the second stage
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         meta <= INIT;
         sync_out <= INIT;
      end else if (enable_in) begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule : pin_sync

// *** external_bus_host_interface.sv ***
// External bus master, slave and host hand-over logic for one processor
// How it works
// - Write strobe low during our external writes and internal-memory writes.
// - Page output pulses when an access crosses a DRAM page boundary.
// - Page output only for bank 0 and only while we are master.
// - Only the bus master drives the timing reference output.
// - Sync write select warns early; write aborted if strobe never follows.
// - Sync write select asserted in the cycle the address is driven.
// - As slave, sync write select tells read from write.
// - Acknowledge driven low while our memory needs wait states on a bus-master access; not driven for a host access.
// - As slave, pull master's acknowledge low for needed cycles.
// - Master keeps acknowledge at last driven level when undriven.
// - Suspend low floats address, data, selects and strobes three clocks after the pin is sampled.
// - Access attempted under suspend stalls until suspend releases.
// - Host request low makes master release bus and assert grant.
// - Releasing bus floats address, data, select and strobe lines.
// - Host request beats all processor bus requests.
// - Grant stays low until host drops request; master drives it.
// - Host ready held low for waits during asynchronous host access.
// - Host ready driven only with a chip select and host request.
// - Read strobe low during our external reads and internal reads.
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module external_bus_host_interface
   import ext_bus_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic clk_en_in,
   // Core side
   input wire core_req_s core_req_in,
   input wire logic [`PAGE_SEL_W-1:0] page_size_sel_in,
   input wire logic is_master_in,
   input wire logic [1:0] my_select_idx_in,
   input wire logic mp_win_in,
   output logic core_done_out,
   output logic core_stall_out,
   output data_t core_rdata_out,
   output logic mp_bus_request_n_out,
   // Slave-side internal memory port
   output logic mem_req_out,
   output logic mem_write_out,
   output addr_t mem_addr_out,
   output data_t mem_wdata_out,
   input wire data_t mem_rdata_in,
   // Shared bus, three signals per two-way pin
   input wire addr_t addr_in,
   input wire data_t data_in,
   input wire logic rd_n_in,
   input wire logic wr_n_in,
   input wire logic sync_write_select_n_in,
   input wire logic ack_in,
   input wire logic ack_oe_in,
   input wire logic suspend_bus_hiz_n_in,
   input wire logic host_bus_request_n_in,
   input wire logic proc_a_select_n_in,
   input wire logic proc_b_select_n_in,
   input wire logic proc_c_select_n_in,
   input wire logic proc_d_select_n_in,
   output bus_drive_s bus_out,
   output logic bus_timing_reference_out,
   output logic bus_timing_reference_oe_out,
   output logic ack_out,
   output logic ack_oe_out,
   output logic host_bus_grant_n_out,
   output logic host_bus_grant_n_oe_out,
   output logic host_ready_n_out,
   output logic host_ready_n_oe_out
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic s_rd_n, s_wr_n, s_sw_n, s_susp_n, s_hreq_n, s_ack;
   logic [3:0] s_sel_n;
   addr_t s_addr;
   data_t s_data;
   logic unused_bit;
   // Control pins idle high; bus values pass through the same kind of sync but reset to zero
   pin_sync #(.WIDTH(11), .INIT(11'h7FF)) u_ctl_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .enable_in(clk_en_in),
      .async_in({rd_n_in, wr_n_in, sync_write_select_n_in, suspend_bus_hiz_n_in,
                 host_bus_request_n_in, ack_in, proc_d_select_n_in,
                 proc_c_select_n_in, proc_b_select_n_in, proc_a_select_n_in,
                 1'b1}),
      .sync_out({s_rd_n, s_wr_n, s_sw_n, s_susp_n, s_hreq_n, s_ack, s_sel_n[3],
                 s_sel_n[2], s_sel_n[1], s_sel_n[0], unused_bit})
   );
   pin_sync #(.WIDTH(`ADDR_W + `DATA_W), .INIT('0)) u_bus_sync (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .enable_in(clk_en_in),
      .async_in({addr_in, data_in}),
      .sync_out({s_addr, s_data})
   );

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Page index of an address for the selected page size
   function automatic addr_t page_of(input addr_t a, input logic [`PAGE_SEL_W-1:0] sel);
      page_of = a >> (`PAGE_BASE_SHIFT + int'(sel));
   endfunction : page_of

   // Access may begin only with the bus ours and no suspend seen or pending
   function automatic logic may_start(input logic valid, input logic own, input logic sn,
                                      input logic sd);
      may_start = valid && own && sn && !sd;
   endfunction : may_start

   // ------------------------------------------------------------
   // Host arbitration and grant
   // ------------------------------------------------------------
   logic granted;
   logic ack_keep;
   master_state_e state;
   logic host_req;
   assign host_req = !s_hreq_n;
   // Grant only when no master access is mid-cycle; host beats processor requests
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         granted <= 1'b0;
      end else if (clk_en_in) begin
         if (!host_req) begin
            granted <= 1'b0;
         end else if (is_master_in && state == M_IDLE) begin
            granted <= 1'b1;
         end
      end
   end
   assign host_bus_grant_n_out = !granted;
   assign host_bus_grant_n_oe_out = is_master_in;

   // ------------------------------------------------------------
   // Processor bus request
   // ------------------------------------------------------------
   // Own processor request withheld while the host asks for the bus
   assign mp_bus_request_n_out = !(core_req_in.valid && !is_master_in && !host_req);

   // ------------------------------------------------------------
   // Wait settle timer
   // ------------------------------------------------------------
   logic [3:0] settle;
   // Synchronised acknowledge and data lag the strobe, so hold off the sample
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         settle <= 4'h0;
      end else if (clk_en_in) begin
         if (state == M_ADDR) begin
            settle <= `ACK_SETTLE_CYCLES;
         end else if (state == M_WAIT && settle != 4'h0) begin
            settle <= settle - 4'h1;
         end
      end
   end

   // ------------------------------------------------------------
   // Master access sequencer
   // ------------------------------------------------------------
   logic own_bus;
   logic susp_d;
   addr_t last_page;
   logic last_page_ok;
   logic page_flag;
   core_req_s cur;
   assign own_bus = is_master_in && !granted && !host_req;
   // Suspend takes effect on the cycle after it is seen
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         susp_d <= 1'b0;
      end else if (clk_en_in) begin
         susp_d <= !s_susp_n;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         state <= M_IDLE;
         cur <= '0;
         core_done_out <= 1'b0;
         core_rdata_out <= '0;
      end else if (clk_en_in) begin
         core_done_out <= 1'b0;
         case (state)
            M_IDLE: begin
               // Stall instead of starting while suspended
               if (may_start(core_req_in.valid, own_bus, s_susp_n, susp_d)) begin
                  cur <= core_req_in;
                  state <= M_ADDR;
               end
            end
            M_ADDR: begin
               state <= M_WAIT;
            end
            M_WAIT: begin
               // Completion needs settled acknowledge high and no suspend
               // Settle covers pin sync plus keeper, else a stale high slips through
               if (settle == 4'h0 && ack_keep && s_susp_n) begin
                  if (!cur.write) begin
                     core_rdata_out <= s_data;
                  end
                  core_done_out <= 1'b1;
                  state <= M_HOLD;
               end
            end
            M_HOLD: begin
               state <= M_IDLE;
            end
            default: begin
               state <= M_IDLE;
            end
         endcase
      end
   end
   assign core_stall_out = core_req_in.valid && (state != M_IDLE || !own_bus || !s_susp_n);

   // ------------------------------------------------------------
   // Page boundary tracking
   // ------------------------------------------------------------
   // Page boundary tracking for bank 0
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         last_page <= '0;
         last_page_ok <= 1'b0;
         page_flag <= 1'b0;
      end else if (clk_en_in) begin
         page_flag <= 1'b0;
         if (state == M_IDLE && may_start(core_req_in.valid, own_bus, s_susp_n, susp_d)
             && core_req_in.bank == `BANK_W'(`DRAM_BANK)) begin
            page_flag <= !last_page_ok
                         || page_of(core_req_in.addr, page_size_sel_in) != last_page;
            last_page <= page_of(core_req_in.addr, page_size_sel_in);
            last_page_ok <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Acknowledge keeper
   // ------------------------------------------------------------
   // Keeper on the acknowledge pin as seen by the master
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         ack_keep <= 1'b1;
      end else if (clk_en_in) begin
         if (ack_oe_in || ack_oe_out) begin
            ack_keep <= s_ack;
         end
      end
   end

   // ------------------------------------------------------------
   // Bus pin drive
   // ------------------------------------------------------------
   logic active;
   logic drive_ok;
   assign active = state == M_ADDR || state == M_WAIT;
   // Floating when suspended, granted away, or not master
   assign drive_ok = own_bus && !susp_d;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         bus_out <= '{addr: '0, data: '0, bank_sel_n: '1, rd_n: 1'b1, wr_n: 1'b1,
                      sw_n: 1'b1, page: 1'b0, addr_oe: 1'b0, data_oe: 1'b0,
                      ctl_oe: 1'b0};
      end else if (clk_en_in) begin
         bus_out.addr_oe <= drive_ok;
         bus_out.ctl_oe <= drive_ok;
         bus_out.data_oe <= drive_ok && cur.write && active;
         bus_out.addr <= cur.addr;
         bus_out.data <= cur.data;
         bus_out.bank_sel_n <= active ? ~(`BANK_W'(1) << cur.bank) : '1;
         bus_out.sw_n <= !(active && cur.write);
         bus_out.wr_n <= !(state == M_WAIT && cur.write && cur.cond_ok);
         bus_out.rd_n <= !(state == M_WAIT && !cur.write);
         bus_out.page <= page_flag && drive_ok;
      end
   end
   // Timing reference follows the core clock, driven only by the master
   assign bus_timing_reference_out = clock_in;
   assign bus_timing_reference_oe_out = drive_ok;

   // ------------------------------------------------------------
   // Slave access to internal memory
   // ------------------------------------------------------------
   logic my_sel, host_acc, mp_acc, slv_busy, slv_write;
   logic [3:0] slv_wait;
   assign my_sel = !s_sel_n[my_select_idx_in];
   assign host_acc = my_sel && host_req;
   // Master-to-slave access decoded from a select of ours on the shared bus
   assign mp_acc = !is_master_in && !host_req && my_sel;
   always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
         slv_busy <= 1'b0;
         slv_wait <= '0;
         slv_write <= 1'b0;
         mem_req_out <= 1'b0;
         mem_write_out <= 1'b0;
         mem_addr_out <= '0;
         mem_wdata_out <= '0;
      end else if (clk_en_in) begin
         mem_req_out <= 1'b0;
         if (!slv_busy && (host_acc || mp_acc) && (!s_rd_n || !s_sw_n)) begin
            slv_busy <= 1'b1;
            slv_write <= !s_sw_n;
            slv_wait <= host_acc ? `HOST_WAIT_CYCLES : `SLAVE_WAIT_CYCLES;
         end else if (slv_busy) begin
            if (slv_wait != 4'h0) begin
               slv_wait <= slv_wait - 4'h1;
            end else begin
               // Write completes only once the strobe arrives
               if (!slv_write || !s_wr_n) begin
                  mem_req_out <= 1'b1;
                  mem_write_out <= slv_write;
                  mem_addr_out <= s_addr;
                  mem_wdata_out <= s_data;
                  slv_busy <= 1'b0;
               end
               if (s_sw_n && s_wr_n && slv_write) begin
                  slv_busy <= 1'b0;
               end
            end
         end
      end
   end
   // Acknowledge low while wait states remain on a bus-master access
   assign ack_out = !(slv_busy && slv_wait != 4'h0);
   assign ack_oe_out = slv_busy && !host_acc;

   // ------------------------------------------------------------
   // Host ready
   // ------------------------------------------------------------
   // Ready held low during waits of an asynchronous host access
   assign host_ready_n_out = !(slv_busy && slv_wait != 4'h0);
   assign host_ready_n_oe_out = host_acc && !host_ready_n_out;
endmodule : external_bus_host_interface

// *** ext_bus_host_sva.sv ***
// Concurrent checks on the external bus host interface ports
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module ext_bus_host_sva
   import ext_bus_pkg::*;
(
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire core_req_s core_req_in,
   input wire logic is_master_in,
   input wire logic core_done_out,
   input wire logic core_stall_out,
   input wire logic suspend_bus_hiz_n_in,
   input wire logic host_bus_request_n_in,
   input wire bus_drive_s bus_out,
   input wire logic bus_timing_reference_oe_out,
   input wire logic ack_oe_out,
   input wire logic host_bus_grant_n_out,
   input wire logic host_ready_n_oe_out
);
// ----------------------------------------
// Properties
// ----------------------------------------
default clocking cb @(posedge clock_in); endclocking
default disable iff (!rst_n_in);
logic quiet;
// Bus fully floated
assign quiet = !bus_out.addr_oe && !bus_out.data_oe && !bus_out.ctl_oe;
sequence s_req_held; !host_bus_request_n_in [*3]; endsequence
sequence s_suspended; !suspend_bus_hiz_n_in [*5]; endsequence
property p_grant_hold; s_req_held ##0 !host_bus_grant_n_out |=> !host_bus_grant_n_out; endproperty
a_grant_hold: assert property (p_grant_hold) else $error("grant dropped early");
property p_release; !host_bus_grant_n_out ##1 !host_bus_grant_n_out |-> quiet; endproperty
a_release: assert property (p_release) else $error("bus driven under grant");
property p_slave_float; !is_master_in && !$past(is_master_in) |-> quiet; endproperty
a_slave_float: assert property (p_slave_float) else $error("slave drives bus");
property p_ref_owner; bus_timing_reference_oe_out |-> is_master_in; endproperty
a_ref_owner: assert property (p_ref_owner) else $error("reference driven by slave");
property p_page_bank0; bus_out.page |-> !bus_out.bank_sel_n[`DRAM_BANK]; endproperty
a_page_bank0: assert property (p_page_bank0) else $error("page outside bank 0");
property p_sw_addr; $fell(bus_out.sw_n) |-> bus_out.addr_oe && !(&bus_out.bank_sel_n); endproperty
a_sw_addr: assert property (p_sw_addr) else $error("select without address");
property p_wr_after_sw; $fell(bus_out.wr_n) |-> $past(!bus_out.sw_n); endproperty
a_wr_after_sw: assert property (p_wr_after_sw) else $error("strobe without warning");
property p_susp_float; s_suspended |-> quiet; endproperty
a_susp_float: assert property (p_susp_float) else $error("bus driven in suspend");
property p_susp_stall;
   s_suspended ##0 (core_req_in.valid && is_master_in) |-> core_stall_out && !core_done_out;
endproperty
a_susp_stall: assert property (p_susp_stall) else $error("access ran in suspend");
property p_ready_gate; host_ready_n_oe_out |-> !$past(host_bus_request_n_in, 2); endproperty
a_ready_gate: assert property (p_ready_gate) else $error("ready without request");
property p_ack_slave; ack_oe_out |-> !is_master_in; endproperty
a_ack_slave: assert property (p_ack_slave) else $error("master drives ack");
endmodule : ext_bus_host_sva
bind external_bus_host_interface ext_bus_host_sva i_ext_bus_host_sva (
   .clock_in(clock_in), .rst_n_in(rst_n_in), .core_req_in(core_req_in),
   .is_master_in(is_master_in), .core_done_out(core_done_out),
   .core_stall_out(core_stall_out), .suspend_bus_hiz_n_in(suspend_bus_hiz_n_in),
   .host_bus_request_n_in(host_bus_request_n_in), .bus_out(bus_out),
   .bus_timing_reference_oe_out(bus_timing_reference_oe_out), .ack_oe_out(ack_oe_out),
   .host_bus_grant_n_out(host_bus_grant_n_out), .host_ready_n_oe_out(host_ready_n_oe_out));

// *** ext_mem_model.sv ***
// Behavioural external memory answering the bus master
`timescale 1ns/1ps
module ext_mem_model
   import ext_bus_pkg::*;
(
   input wire logic clock_in,
   input wire bus_drive_s bus_in,
   input wire logic [3:0] waits_in,
   output logic ack_out,
   output logic ack_oe_out,
   output data_t data_out,
   output logic data_oe_out
);
logic [3:0] count;
logic [2:0] linger;
logic strobe;
data_t last;
// Only answer strobes that the master really drives
assign strobe = bus_in.ctl_oe && !(bus_in.rd_n && bus_in.wr_n);
// Wait counter restarts with every new strobe
always_ff @(posedge clock_in) begin
   if (!strobe) count <= 4'h0;
   else if (count < waits_in) count <= count + 4'h1;
end
assign ack_oe_out = strobe;
assign ack_out = strobe ? (count >= waits_in) : 1'b1;
// Read data kept a few cycles past the strobe, then its fixed inverse
always_ff @(posedge clock_in) begin
   if (strobe && !bus_in.rd_n) begin
      linger <= 3'h3;
      last <= {bus_in.addr[15:0], ~bus_in.addr};
   end else if (linger != 3'h0) linger <= linger - 3'h1;
end
assign data_oe_out = (strobe && !bus_in.rd_n) || linger != 3'h0;
assign data_out = data_oe_out ? last : ~last;
endmodule : ext_mem_model

// *** test_external_bus_host_interface.sv ***
// Self-checking bench for the external bus host interface
`timescale 1ns/1ps
module test_external_bus_host_interface
   import ext_bus_pkg::*;
;
typedef struct packed { logic [1:0] kind; addr_t addr; data_t data; } note_s;
logic clock_in = 0, rst_n = 0, is_master = 1, sus_n = 1, hreq_n = 1, wr_prev = 1;
logic h_wr_n = 1, h_sw_n = 1, done, stall, mp_n, m_req, m_wr, ack_o, ack_oe, p_ack, p_aoe;
logic p_doe, grant_n, rdy_oe;
logic [3:0] cs_n = 4'hF, waits = 4'h0;
logic [2:0] psel = 3'h0;
logic [1:0] sel = 2'h0;
core_req_s req = '0;
addr_t h_addr = '0, a_w, m_addr;
data_t h_data = '0, m_wdata, c_rdata, p_data;
bus_drive_s bus;
int seed = 68128, bad_count = 0, n_checks = 0, cycles = 0, pages = 0, p0, l0, l3;
note_s notes[$];
initial forever #25 clock_in = ~clock_in;
external_bus_host_interface i_external_bus_host_interface (.clock_in(clock_in),
   .rst_n_in(rst_n), .clk_en_in(1'b1), .core_req_in(req), .page_size_sel_in(psel),
   .is_master_in(is_master), .my_select_idx_in(sel), .mp_win_in(1'b0),
   .core_done_out(done), .core_stall_out(stall), .core_rdata_out(c_rdata),
   .mp_bus_request_n_out(mp_n), .mem_req_out(m_req), .mem_write_out(m_wr),
   .mem_addr_out(m_addr), .mem_wdata_out(m_wdata), .mem_rdata_in(48'h0000_5A5A_0F0F),
   .addr_in(bus.addr_oe ? bus.addr : h_addr),
   .data_in(bus.data_oe ? bus.data : (p_doe ? p_data : h_data)),
   .rd_n_in(bus.ctl_oe ? bus.rd_n : 1'b1), .wr_n_in(bus.ctl_oe ? bus.wr_n : h_wr_n),
   .sync_write_select_n_in(bus.ctl_oe ? bus.sw_n : h_sw_n),
   .ack_in(ack_oe ? ack_o : p_ack), .ack_oe_in(p_aoe), .suspend_bus_hiz_n_in(sus_n),
   .host_bus_request_n_in(hreq_n), .proc_a_select_n_in(cs_n[0]),
   .proc_b_select_n_in(cs_n[1]), .proc_c_select_n_in(cs_n[2]), .proc_d_select_n_in(cs_n[3]),
   .bus_out(bus), .bus_timing_reference_out(), .bus_timing_reference_oe_out(),
   .ack_out(ack_o), .ack_oe_out(ack_oe), .host_bus_grant_n_out(grant_n),
   .host_bus_grant_n_oe_out(), .host_ready_n_out(), .host_ready_n_oe_out(rdy_oe));
ext_mem_model i_ext_mem_model (.clock_in(clock_in), .bus_in(bus), .waits_in(waits),
   .ack_out(p_ack), .ack_oe_out(p_aoe), .data_out(p_data), .data_oe_out(p_doe));
// ----------------------------------------
// Checking tasks
// ----------------------------------------
task automatic check(input logic ok, input string what);
   n_checks++;
   if (ok !== 1'b1) begin
      bad_count++;
      $display("MISMATCH at %0t: %s", $time, what);
   end
endtask : check
task automatic take(input note_s got);
   note_s exp;
   exp = (notes.size() > 0) ? notes.pop_front() : ~got;
   check(got === exp, "result differs from note");
endtask : take
task automatic test_done();
   $display("checks %0d mismatches %0d", n_checks, bad_count);
   if (bad_count == 0 && n_checks > 0) $display("Test passed");
   else $display("Test failed");
   $finish;
endtask : test_done
// Watcher pops the oldest note whenever a result shows; also cuts hangs
always @(posedge clock_in) begin
   wr_prev <= bus.wr_n;
   cycles <= cycles + 1;
   if (bus.page === 1'b1) pages <= pages + 1;
   if (rst_n && wr_prev && bus.wr_n === 1'b0) take({2'd0, bus.addr, bus.data});
   if (done === 1'b1 && !req.write) take({2'd1, req.addr, c_rdata});
   if (m_req === 1'b1) take({1'b1, m_wr, m_addr, m_wdata});
   if (cycles == 20000) begin
      check(1'b0, "timeout");
      test_done();
   end
end
// Core request plus its note; data kept to the full word
task automatic start(input logic wr, input logic [3:0] bank, input addr_t a);
   data_t d;
   d = {16'($random(seed)), 32'($random(seed))};
   req = {1'b1, wr, 1'b1, bank, a, d};
   notes.push_back(wr ? {2'd0, a, d} : {2'd1, a, a[15:0], ~a});
endtask : start
task automatic finish(output int lat);
   lat = 0;
   while (done !== 1'b1 && lat < 60) begin
      @(posedge clock_in);
      lat++;
   end
   check(lat < 60, "access never completed");
   @(negedge clock_in);
   req.valid = 1'b0;
   @(negedge clock_in);
endtask : finish
// ----------------------------------------
// Main sequence, inputs change on falling edges
// ----------------------------------------
initial begin
   repeat (10) @(negedge clock_in);
   rst_n = 1;
   repeat (3) @(negedge clock_in);
   for (int i = 0; i < 8; i++) begin
      waits = 4'($random(seed)) & 4'h3;
      start(i[0], 4'($random(seed)) & 4'h3, $random(seed));
      finish(l0);
   end
   waits = 4'h0;
   start(1'b1, 4'h1, $random(seed));
   finish(l0);
   waits = 4'h3;
   start(1'b1, 4'h1, $random(seed));
   finish(l3);
   check(l3 - l0 == 3, "wait states not honoured");
   $display("end of read, write and wait test");
   waits = 4'h0;
   psel = 3'($random(seed)) & 3'h3;
   a_w = $random(seed) & 32'hFFFF_F000;
   start(1'b1, 4'h0, a_w);
   finish(l0);
   p0 = pages;
   start(1'b1, 4'h0, a_w + 32'h1);
   finish(l0);
   check(pages == p0, "page flagged within page");
   start(1'b0, 4'h0, a_w + (32'h0000_0100 << psel));
   finish(l0);
   start(1'b1, 4'h1, a_w + (32'h0000_0200 << psel));
   finish(l0);
   check(pages == p0 + 1, "page boundary count");
   $display("end of page test");
   sus_n = 0;
   repeat (6) @(negedge clock_in);
   start(1'b0, 4'h2, $random(seed));
   repeat (8) @(negedge clock_in);
   check(stall === 1'b1, "no stall in suspend");
   sus_n = 1;
   finish(l0);
   $display("end of suspend test");
   hreq_n = 0;
   for (l0 = 0; grant_n !== 1'b0 && l0 < 20; l0++) @(negedge clock_in);
   check(grant_n === 1'b0, "no grant");
   start(1'b1, 4'h3, $random(seed));
   repeat (4) @(negedge clock_in);
   check(mp_n === 1'b1 && bus.addr_oe === 1'b0 && stall === 1'b1, "bus kept");
   hreq_n = 1;
   finish(l0);
   check(grant_n === 1'b1, "grant held after release");
   $display("end of host grant test");
   is_master = 0;
   sel = 2'($random(seed));
   cs_n[sel] = 1'b0;
   hreq_n = 0;
   h_addr = $random(seed);
   h_data = {16'($random(seed)), 32'($random(seed))};
   h_sw_n = 0;
   notes.push_back({2'd3, h_addr, h_data});
   @(negedge clock_in);
   h_wr_n = 0;
   repeat (3) @(negedge clock_in);
   check(rdy_oe === 1'b1, "host ready not held low in wait");
   @(negedge clock_in);
   h_wr_n = 1;
   h_sw_n = 1;
   repeat (4) @(negedge clock_in);
   h_sw_n = 0;
   repeat (3) @(negedge clock_in);
   h_sw_n = 1;
   repeat (8) @(negedge clock_in);
   cs_n = 4'hF;
   hreq_n = 1;
   check(notes.size() == 0, "results missing");
   $display("end of slave write test");
   test_done();
end
endmodule : test_external_bus_host_interface
